// >>> design/sec_clock_map.svh
// Register offsets, field positions and reset values of the clock control.
`ifndef SEC_CLOCK_MAP_SVH
`define SEC_CLOCK_MAP_SVH
`define CLK_CTRL_OFFSET    12'ha4
`define PM_STATE_OFFSET    12'hb8
`define CLK_CTRL_RESET     32'h0000_0000
`define CLK_CTRL_WMASK     32'h0000_c7ff
`define DEV_CLK1_BIT       8
`define DEV_CLK2_BIT       9
`define FEEDBACK_BIT       10
`define STOP_STATUS_BIT    13
`define CLKRUN_EN_BIT      14
`define CLKRUN_MODE_BIT    15
`define SLOT_STOP_CODE     2'h3
`define PM_D0              2'h0
`define PM_D3              2'h3
`endif

// >>> design/sec_clock_pkg.sv
// Types shared by the secondary clock control.
package sec_clock_pkg;
    typedef enum logic [1:0] {
        CLK_RUNNING,
        CLK_STOPPED
    } clk_state_t;
endpackage

// >>> design/sec_clock_ctrl.sv
// Secondary clock gating and clock-stop control with an APB register slave.
// Function
// - Slot clock code 11 stops, holds low
// - Bits 8, 9 stop device clocks
// - Bit 10 gates feedback clock, forward only
// - Bit 13 reports secondary clock stopped
// - Bit 14 enables; default stops in D3hot
// - Mode 1 stops when idle, no request
// - Power state 11 is D3, 00 is D0; 01 and 10 ignored
`include "sec_clock_map.svh"
module sec_clock_ctrl
    import sec_clock_pkg::*;
(
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Bridge status, same clock domain
    input  wire logic        forward_mode,
    input  wire logic        sec_bus_idle,
    input  wire logic        primary_req_pending,
    // Secondary clock source and gated outputs
    input  wire logic        sec_clock_run,
    output logic             slot0_clock_out,
    output logic             slot1_clock_out,
    output logic             slot2_clock_out,
    output logic             slot3_clock_out,
    output logic             device1_clock_out,
    output logic             device2_clock_out,
    output logic             bridge_feedback_clock_out
);

    logic [31:0] ctrl_ff;
    logic [31:0] nxt_ctrl;
    logic [1:0]  pm_ff;
    logic [1:0]  nxt_pm;
    clk_state_t  state_ff;
    clk_state_t  nxt_state;
    logic [31:0] prdata_ff;
    logic [31:0] nxt_prdata;
    logic        pready_ff;
    logic        nxt_pready;
    logic        pslverr_ff;
    logic        nxt_pslverr;
    logic [6:0]  gate_ff;
    logic [6:0]  nxt_gate;
    logic        stop_cond;
    logic        access;

    function automatic logic slot_on(input logic [1:0] code);
        slot_on = (code != `SLOT_STOP_CODE);
    endfunction

    assign access = psel && penable && !pready_ff;

    // A zero-wait slave would need pready combinational; one wait state
    // keeps every output registered.
    always_comb
    begin
        nxt_ctrl    = ctrl_ff;
        nxt_pm      = pm_ff;
        nxt_prdata  = prdata_ff;
        nxt_pready  = access;
        nxt_pslverr = 1'b0;
        if (access)
        begin
            if (paddr == `CLK_CTRL_OFFSET)
            begin
                if (pwrite)
                    nxt_ctrl = (ctrl_ff & ~`CLK_CTRL_WMASK)
                             | (pwdata & `CLK_CTRL_WMASK);
                else
                    nxt_prdata = ctrl_ff;
            end
            else if (paddr == `PM_STATE_OFFSET)
            begin
                // D1 and D2 are not implemented, so such writes are dropped.
                if (pwrite && (pwdata[1:0] == `PM_D0
                               || pwdata[1:0] == `PM_D3))
                    nxt_pm = pwdata[1:0];
                nxt_prdata = {30'h0, pm_ff};
            end
            else
            begin
                nxt_pslverr = 1'b1;
                nxt_prdata  = 32'h0;
            end
        end
        // Status is hardware owned and tracks the clock state.
        nxt_ctrl[`STOP_STATUS_BIT] = (state_ff == CLK_STOPPED);
    end

    // Stop condition for each clock-stop mode.
    always_comb
    begin
        if (!ctrl_ff[`CLKRUN_EN_BIT])
            stop_cond = 1'b0;
        else if (ctrl_ff[`CLKRUN_MODE_BIT])
            stop_cond = sec_bus_idle && !primary_req_pending;
        else
            stop_cond = (pm_ff == `PM_D3);
    end

    always_comb
    begin
        case (state_ff)
            CLK_RUNNING:
                nxt_state = stop_cond ? CLK_STOPPED : CLK_RUNNING;
            CLK_STOPPED:
                nxt_state = stop_cond ? CLK_STOPPED : CLK_RUNNING;
            default:
                nxt_state = CLK_RUNNING;
        endcase
    end

    // Gated outputs are held low; the stopped secondary clock gates all.
    always_comb
    begin
        logic run;
        run = sec_clock_run && (state_ff == CLK_RUNNING);
        nxt_gate[0] = run && slot_on(ctrl_ff[1:0]);
        nxt_gate[1] = run && slot_on(ctrl_ff[3:2]);
        nxt_gate[2] = run && slot_on(ctrl_ff[5:4]);
        nxt_gate[3] = run && slot_on(ctrl_ff[7:6]);
        nxt_gate[4] = run && !ctrl_ff[`DEV_CLK1_BIT];
        nxt_gate[5] = run && !ctrl_ff[`DEV_CLK2_BIT];
        nxt_gate[6] = run && forward_mode
                    && !ctrl_ff[`FEEDBACK_BIT];
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_ff    <= `CLK_CTRL_RESET;
            pm_ff      <= `PM_D0;
            state_ff   <= CLK_RUNNING;
            prdata_ff  <= 32'h0;
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            gate_ff    <= 7'h0;
        end
        else
        begin
            ctrl_ff    <= nxt_ctrl;
            pm_ff      <= nxt_pm;
            state_ff   <= nxt_state;
            prdata_ff  <= nxt_prdata;
            pready_ff  <= nxt_pready;
            pslverr_ff <= nxt_pslverr;
            gate_ff    <= nxt_gate;
        end
    end

    assign prdata                    = prdata_ff;
    assign pready                    = pready_ff;
    assign pslverr                   = pslverr_ff;
    assign slot0_clock_out           = gate_ff[0];
    assign slot1_clock_out           = gate_ff[1];
    assign slot2_clock_out           = gate_ff[2];
    assign slot3_clock_out           = gate_ff[3];
    assign device1_clock_out         = gate_ff[4];
    assign device2_clock_out         = gate_ff[5];
    assign bridge_feedback_clock_out = gate_ff[6];

    property p_slot_stop;
        @(posedge pclk) disable iff (!presetn)
        ctrl_ff[1:0] == 2'h3 |=> !slot0_clock_out;
    endproperty
    a_slot_stop: assert property (p_slot_stop)
        else $error("slot 0 clock not held low");

    property p_slot_run;
        @(posedge pclk) disable iff (!presetn)
        (ctrl_ff[7:6] != 2'h3 && sec_clock_run && state_ff == CLK_RUNNING)
        |=> slot3_clock_out;
    endproperty
    a_slot_run: assert property (p_slot_run)
        else $error("slot 3 clock not running");

    property p_dev_stop;
        @(posedge pclk) disable iff (!presetn)
        ctrl_ff[9] |=> !device2_clock_out;
    endproperty
    a_dev_stop: assert property (p_dev_stop)
        else $error("device 2 clock not held low");

    property p_fb_reverse;
        @(posedge pclk) disable iff (!presetn)
        (!forward_mode || ctrl_ff[10]) |=> !bridge_feedback_clock_out;
    endproperty
    a_fb_reverse: assert property (p_fb_reverse)
        else $error("feedback clock running when gated");

    property p_status;
        @(posedge pclk) disable iff (!presetn)
        (state_ff == CLK_STOPPED) |=> ctrl_ff[13];
    endproperty
    a_status: assert property (p_status)
        else $error("stop status not set");

    property p_disabled;
        @(posedge pclk) disable iff (!presetn)
        !ctrl_ff[14] |=> state_ff == CLK_RUNNING;
    endproperty
    a_disabled: assert property (p_disabled)
        else $error("clock stopped while protocol disabled");

    property p_idle_stop;
        @(posedge pclk) disable iff (!presetn)
        (ctrl_ff[14] && ctrl_ff[15] && sec_bus_idle && !primary_req_pending)
        |=> state_ff == CLK_STOPPED;
    endproperty
    a_idle_stop: assert property (p_idle_stop)
        else $error("idle bus did not stop clock");

    property p_pm_ignore;
        @(posedge pclk) disable iff (!presetn)
        (access && pwrite && paddr == 12'hb8
         && (pwdata[1:0] == 2'h1 || pwdata[1:0] == 2'h2))
        |=> $stable(pm_ff);
    endproperty
    a_pm_ignore: assert property (p_pm_ignore)
        else $error("unimplemented power state accepted");

    property p_restart;
        @(posedge pclk) disable iff (!presetn)
        (state_ff == CLK_STOPPED && !stop_cond)
        |=> state_ff == CLK_RUNNING ##1 !ctrl_ff[13];
    endproperty
    a_restart: assert property (p_restart)
        else $error("clock did not restart");

endmodule

// >>> tb/sec_bus_model.sv
// Behavioural secondary bus: clock source and bus activity.
module sec_bus_model
(
    // Clock
    input  wire logic pclk,
    // Activity request from the bench
    input  wire logic busy,
    // Toward the block
    output logic      clk_src,
    output logic      idle
);
    timeunit 1ns;
    timeprecision 1ps;
    // The source toggles every cycle, so a running output is never flat.
    logic src_ff = 1'b0;
    always @(posedge pclk) src_ff <= ~src_ff;
    assign clk_src = src_ff;
    assign idle = ~busy;
endmodule

// >>> tb/tb_sec_clock_ctrl.sv
// Self-checking bench of the secondary clock control.
module tb_sec_clock_ctrl;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, fwd = 1, req = 0, busy = 1, src, idle, er;
    wire [6:0] co;
    int err_count = 0, n_tests = 0;
    always #25 pclk = ~pclk;
    sec_bus_model peer (.pclk(pclk), .busy(busy), .clk_src(src),
                        .idle(idle));
    sec_clock_ctrl dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .forward_mode(fwd), .sec_bus_idle(idle),
        .primary_req_pending(req), .sec_clock_run(src),
        .slot0_clock_out(co[0]), .slot1_clock_out(co[1]),
        .slot2_clock_out(co[2]), .slot3_clock_out(co[3]),
        .device1_clock_out(co[4]), .device2_clock_out(co[5]),
        .bridge_feedback_clock_out(co[6]));
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e)
        begin
            err_count++;
            $display("unexpected t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (n >= 20)
        begin
            err_count++;
            final_report();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // A running output toggles, so two samples OR to one; gated stays low.
    task automatic ck(input logic [6:0] m);
        logic [6:0] a;
        repeat (3) @(posedge pclk);
        a = co;
        @(posedge pclk);
        chk({25'h0, a | co}, {25'h0, m});
    endtask
    task automatic t_gate();
        for (int c = 0; c < 4; c++)
        begin
            apb(1'b1, 12'ha4, {24'h0, {4{c[1:0]}}});
            ck(c == 3 ? 7'h70 : 7'h7f);
        end
        apb(1'b1, 12'ha4, 32'h0000_0300);
        ck(7'h4f);
        apb(1'b1, 12'ha4, 32'h0000_0400);
        ck(7'h3f);
        // In reverse mode the feedback output stays low even when enabled.
        apb(1'b1, 12'ha4, 32'h0000_0000);
        fwd <= 1'b0;
        ck(7'h3f);
        fwd <= 1'b1;
        $display("test gate done");
    endtask
    task automatic t_regs();
        apb(1'b1, 12'ha4, 32'hffff_ffff);
        apb(1'b0, 12'ha4, 32'h0);
        chk(rd, 32'h0000_c7ff);
        apb(1'b0, 12'h010, 32'h0);
        chk({31'h0, er}, 32'h1);
        $display("test regs done");
    endtask
    task automatic t_d3();
        apb(1'b1, 12'ha4, 32'h0000_4000);
        apb(1'b1, 12'hb8, 32'h3);
        ck(7'h00);
        apb(1'b0, 12'ha4, 32'h0);
        chk(rd, 32'h0000_6000);
        apb(1'b1, 12'hb8, 32'h1);
        apb(1'b0, 12'hb8, 32'h0);
        chk(rd, 32'h3);
        apb(1'b1, 12'hb8, 32'h0);
        ck(7'h7f);
        apb(1'b0, 12'ha4, 32'h0);
        chk(rd, 32'h0000_4000);
        $display("test d3 done");
    endtask
    task automatic t_idle();
        apb(1'b1, 12'ha4, 32'h0000_c000);
        busy <= 1'b0;
        ck(7'h00);
        req <= 1'b1;
        ck(7'h7f);
        req <= 1'b0;
        ck(7'h00);
        apb(1'b1, 12'ha4, 32'h0000_8000);
        ck(7'h7f);
        busy <= 1'b1;
        $display("test idle done");
    endtask
    initial
    begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 12'ha4, 32'h0);
        chk(rd, 32'h0);
        ck(7'h7f);
        t_gate();
        t_regs();
        t_d3();
        t_idle();
        final_report();
    end
endmodule
